// [rtl/clk_sel_pkg.sv]
// constants and types shared by the cpu clock selection logic
package clk_sel_pkg;
  // strap encodings sampled while reset is held
  localparam logic [2:0] STRAP_PRESCALE = 3'h1;
  localparam logic [2:0] STRAP_DIRECT   = 3'h3;
  localparam logic [2:0] STRAP_X4       = 3'h7;
  localparam logic [2:0] STRAP_X3       = 3'h6;
  localparam logic [2:0] STRAP_X8       = 3'h5;
  localparam logic [2:0] STRAP_X5       = 3'h4;

  // system configuration word and the watchdog disable bit in it
  localparam int SYSCFG_W        = 16;
  localparam int OWD_DISABLE_BIT = 4;

  // pll divider chain: input prescaler, vco multiplier, output divider
  localparam int IN_PRESCALE  = 4;
  localparam int VCO_MUL_X4   = 64;
  localparam int VCO_MUL_X3   = 48;
  localparam int VCO_MUL_X8   = 64;
  localparam int VCO_MUL_X5   = 40;
  localparam int POST_DIV_X4  = 4;
  localparam int POST_DIV_X3  = 4;
  localparam int POST_DIV_X8  = 2;
  localparam int POST_DIV_X5  = 2;

  // oscillator watchdog overflow and free running pll rate
  localparam int WD_OVF_TICKS       = 16;
  localparam int WD_CNT_W           = 4;
  localparam int CLK_PERIOD_NS      = 10;
  localparam int FREE_RUN_PERIOD_NS = 40;
  localparam int FREE_RUN_DIV       = (FREE_RUN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FREE_DIV_W         = 2;

  // tracking oscillator of the multiplier
  localparam int          NCO_W         = 16;
  localparam logic [15:0] NCO_INC_RESET = 16'h1000;
  // step sized so an x8 lock on a slow input settles within a few thousand cycles
  localparam logic [15:0] NCO_STEP      = 16'h0200;
  // ceiling leaves headroom for one more step without wrapping
  localparam logic [15:0] NCO_INC_MAX   = 16'hF000;

  typedef enum logic [1:0] {MODE_PRESCALE, MODE_DIRECT, MODE_PLL} clk_mode_t;

  // multiplication factor of the pll chain for a strap code
  function automatic logic [3:0] pll_factor(input logic [2:0] s);
    logic [3:0] f;
    f = 4'(VCO_MUL_X4 / (IN_PRESCALE * POST_DIV_X4));
    unique case (s)
      STRAP_X3: f = 4'(VCO_MUL_X3 / (IN_PRESCALE * POST_DIV_X3));
      STRAP_X8: f = 4'(VCO_MUL_X8 / (IN_PRESCALE * POST_DIV_X8));
      STRAP_X5: f = 4'(VCO_MUL_X5 / (IN_PRESCALE * POST_DIV_X5));
      default:  f = 4'(VCO_MUL_X4 / (IN_PRESCALE * POST_DIV_X4));
    endcase
    return f;
  endfunction : pll_factor
endpackage : clk_sel_pkg

// [rtl/pll_tracker.sv]
// frequency multiplier that tracks the input clock with a tuned oscillator
`timescale 1ns/1ps
`default_nettype none
module pll_tracker
  import clk_sel_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_enable,
  input  wire logic       i_in_edge,
  input  wire logic [3:0] i_factor,
  output var  logic       o_clk
);
  logic [NCO_W-1:0] acc_q, acc_d;
  logic [NCO_W-1:0] inc_q, inc_d;
  logic             clk_q, clk_d;
  logic [7:0]       tog_q, tog_d;
  logic [3:0]       trn_q, trn_d;

  // oscillator step, then a small correction every f-th input transition
  always_comb begin
    logic [NCO_W:0] sum;
    logic [7:0]     target;
    sum    = {1'b0, acc_q} + {1'b0, inc_q};
    target = 8'(i_factor * i_factor); // toggles expected over f transitions
    acc_d  = sum[NCO_W-1:0];
    inc_d  = inc_q;
    clk_d  = sum[NCO_W] ? ~clk_q : clk_q;
    tog_d  = (sum[NCO_W] && tog_q != 8'hFF) ? tog_q + 8'h01 : tog_q;
    trn_d  = trn_q;
    if (i_in_edge) begin
      trn_d = trn_q + 4'h1;
      if (trn_d >= i_factor) begin
        // one step per check keeps the cpu frequency from jumping
        if (tog_d < target && inc_q < NCO_INC_MAX) begin
          inc_d = inc_q + NCO_STEP;
        end else if (tog_d > target && inc_q > NCO_STEP) begin
          inc_d = inc_q - NCO_STEP;
        end
        tog_d = 8'h00;
        trn_d = 4'h0;
      end
    end
    if (!i_enable) begin
      acc_d = '0;
      clk_d = 1'b0;
      tog_d = 8'h00;
      trn_d = 4'h0;
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc_q <= '0;
      inc_q <= NCO_INC_RESET;
      clk_q <= 1'b0;
      tog_q <= 8'h00;
      trn_q <= 4'h0;
    end else begin
      acc_q <= acc_d;
      inc_q <= inc_d;
      clk_q <= clk_d;
      tog_q <= tog_d;
      trn_q <= trn_d;
    end
  end

  assign o_clk = clk_q;
endmodule : pll_tracker
`default_nettype wire

// [rtl/cpu_clock_select.sv]
// cpu clock source selection with oscillator watchdog failover
//
// What this block does
// - Straps 001 in reset give a cpu clock of the input clock divided by two.
// - Straps 011 in reset disable the pll multiplier, bypass the amplifier and pass the input clock straight through.
// - In prescaler or direct mode the pll free-runs for the watchdog unless the disable bit is set, then it is off unless a failure is already latched.
// - Watchdog supervision exists only in the two direct modes, never when the pll multiplies.
// - The watchdog is on after reset and is turned off by bit 4 of the system configuration word.
// - While enabled the watchdog counter counts free-running pll ticks and clears on every input transition.
// - Sixteen pll ticks with no input transition mean the external clock has failed.
// - On a failure the cpu runs from the free-running pll clock and the failure request flag is set.
// - Once failed, the cpu stays on the pll clock until a reset, even if the input clock returns.
// - With the watchdog disabled in prescaler or direct mode and no failure latched, the cpu runs from the input clock and the pll stays off.
// - Any other strap code enables the pll and gives the input frequency times the selected factor.
// - The pll pulls the cpu clock toward the input every f-th input transition, in small steps.
// - Straps 111, 110, 101 and 100 give factors four, three, eight and five; 011 bypasses the pll.
// - The pll chain divides the input by four, multiplies by 64, 48, 64 or 40 and divides by 4, 4, 2 or 2.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_select
  import clk_sel_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_reset,
  input  wire logic                i_clock_input_pin,
  input  wire logic [2:0]          i_clock_select_straps,
  input  wire logic [SYSCFG_W-1:0] i_system_config_register,
  input  wire logic                i_irq_clear,
  output var  logic                o_cpu_clk,
  output var  logic                o_pll_enable,
  output var  logic                o_osc_amp_bypass,
  output var  logic                o_osc_fail_irq,
  output var  logic                o_clock_failed
);
  // pin synchronisers; the first stage feeds only the second
  logic       in_m_q, in_s_q, in_p_q;
  logic [2:0] strap_m_q, strap_s_q;
  logic [2:0] strap_q, strap_d;

  // watchdog, failover and output state
  logic [WD_CNT_W-1:0]   wd_cnt_q, wd_cnt_d;
  logic [FREE_DIV_W-1:0] div_q, div_d;
  logic                  fail_q, fail_d;
  logic                  irq_q, irq_d;
  logic                  cpu_q, cpu_d;
  logic                  pll_on_q, pll_on_d;
  logic                  bypass_q, bypass_d;

  clk_mode_t  mode;
  logic [3:0] factor;
  logic       owd_dis, direct_like, wd_active, in_edge, in_rise, tick, fail_set, pll_clk;

  // decode of the latched straps
  always_comb begin
    unique case (strap_q)
      STRAP_PRESCALE: mode = MODE_PRESCALE;
      STRAP_DIRECT:   mode = MODE_DIRECT;
      default:        mode = MODE_PLL;
    endcase
  end

  assign factor      = pll_factor(strap_q);
  assign owd_dis     = i_system_config_register[OWD_DISABLE_BIT];
  assign direct_like = (mode != MODE_PLL);
  // no supervision while multiplying or once failed
  assign wd_active   = direct_like && !owd_dis && !fail_q;
  assign in_edge     = in_s_q ^ in_p_q;
  assign in_rise     = in_s_q & ~in_p_q;
  assign tick        = pll_on_q && (div_q == FREE_DIV_W'(FREE_RUN_DIV - 1));
  assign fail_set    = wd_active && tick && !in_edge
                       && (wd_cnt_q == WD_CNT_W'(WD_OVF_TICKS - 1));

  // straps track the pins only while reset is held
  assign strap_d = i_reset ? strap_s_q : strap_q;

  // multiplier used in pll modes only
  pll_tracker u_pll (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_enable  (mode == MODE_PLL),
    .i_in_edge (in_edge),
    .i_factor  (factor),
    .o_clk     (pll_clk)
  );

  // next state of watchdog, failover and cpu clock
  always_comb begin
    // free running pll: on for multiplication, for supervision or once failed
    pll_on_d = (mode == MODE_PLL) || (direct_like && !owd_dis) || fail_q;
    bypass_d = (mode == MODE_DIRECT);
    div_d    = (pll_on_q && !tick) ? div_q + 1'b1 : '0;
    wd_cnt_d = wd_cnt_q;
    if (!wd_active || in_edge) begin
      wd_cnt_d = '0;
    end else if (tick) begin
      wd_cnt_d = wd_cnt_q + 1'b1;
    end
    // failure is sticky until reset
    fail_d = fail_q | fail_set;
    // a new failure wins over a clear in the same cycle
    irq_d  = fail_set | (irq_q & ~i_irq_clear);
    cpu_d  = cpu_q;
    if (fail_q) begin
      cpu_d = tick ? ~cpu_q : cpu_q;
    end else begin
      unique case (mode)
        MODE_PRESCALE: cpu_d = in_rise ? ~cpu_q : cpu_q;
        MODE_DIRECT:   cpu_d = in_s_q;
        MODE_PLL:      cpu_d = pll_clk;
      endcase
    end
  end

  // registers; reset restarts supervision from a clean state
  always_ff @(posedge i_clk) begin
    strap_q   <= strap_d;
    in_m_q    <= i_clock_input_pin;
    in_s_q    <= in_m_q;
    // edge history follows the pin through reset so no false edge follows release
    in_p_q    <= in_s_q;
    strap_m_q <= i_clock_select_straps;
    strap_s_q <= strap_m_q;
    if (i_reset) begin
      wd_cnt_q <= '0;
      fail_q   <= 1'b0;
      div_q    <= '0;
      irq_q    <= 1'b0;
      cpu_q    <= 1'b0;
      pll_on_q <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      wd_cnt_q <= wd_cnt_d;
      fail_q   <= fail_d;
      div_q    <= div_d;
      irq_q    <= irq_d;
      cpu_q    <= cpu_d;
      pll_on_q <= pll_on_d;
      bypass_q <= bypass_d;
    end
  end

  assign o_cpu_clk        = cpu_q;
  assign o_pll_enable     = pll_on_q;
  assign o_osc_amp_bypass = bypass_q;
  assign o_osc_fail_irq   = irq_q;
  assign o_clock_failed   = fail_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence quiet_tick_at_top;
    wd_active && tick && !in_edge && wd_cnt_q == 4'hF;
  endsequence

  watchdog_overflow_a: assert property (quiet_tick_at_top |=> fail_q && irq_q)
    else $error("watchdog overflow did not flag a failure");
  counter_clear_a: assert property (wd_active && in_edge |=> wd_cnt_q == 4'h0)
    else $error("input transition did not clear watchdog counter");
  counter_step_a: assert property (wd_active && tick && !in_edge && wd_cnt_q != 4'hF
                                   |=> wd_cnt_q == $past(wd_cnt_q) + 4'h1)
    else $error("watchdog counter did not step on pll tick");
  failover_sticky_a: assert property (fail_q |=> fail_q && o_pll_enable)
    else $error("failover state was lost without reset");
  fail_irq_a: assert property ($rose(fail_q) |-> irq_q)
    else $error("failure did not raise request flag");
  pll_off_a: assert property (!fail_q && direct_like && owd_dis ##1 !fail_q |-> !o_pll_enable)
    else $error("pll on while watchdog disabled");
  prescale_div_a: assert property (!fail_q && mode == MODE_PRESCALE && in_rise
                                   |=> o_cpu_clk != $past(o_cpu_clk))
    else $error("prescaler did not toggle on input rise");
  direct_pass_a: assert property (!fail_q && mode == MODE_DIRECT |=> o_cpu_clk == $past(in_s_q))
    else $error("direct mode did not follow input clock");
  no_supervision_a: assert property (mode == MODE_PLL |=> wd_cnt_q == 4'h0 && !fail_q)
    else $error("watchdog active while pll multiplies");
  failover_clock_a: assert property (fail_q && tick |=> o_cpu_clk != $past(o_cpu_clk))
    else $error("failed cpu clock not driven by pll ticks");
  reset_clean_a: assert property ($fell(i_reset) |-> !fail_q && wd_cnt_q == 4'h0 && !irq_q)
    else $error("reset left watchdog state behind");
endmodule : cpu_clock_select
`default_nettype wire

// [testbench/ext_clk_source.sv]
// behavioural external clock source driving the input clock pin
`timescale 1ns/1ps
`default_nettype none
module ext_clk_source (
  input  wire logic       i_clk,
  input  wire logic       i_run,
  input  wire logic [3:0] i_half,
  output var  logic       o_pin
);
  logic [3:0] cnt_q;

  initial begin
    o_pin = 1'b0;
    cnt_q = 4'h0;
  end

  // toggles every i_half cycles; frozen when stopped, like a dead crystal
  always @(posedge i_clk) begin
    if (!i_run) begin
      cnt_q <= 4'h0;
    end else if (cnt_q >= i_half - 4'h1) begin
      cnt_q <= 4'h0;
      o_pin <= ~o_pin;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : ext_clk_source
`default_nettype wire

// [testbench/cpu_clock_select_bench.sv]
// self-checking bench for the cpu clock selection and oscillator watchdog
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_select_bench
  import clk_sel_pkg::*;
;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                run = 1'b0;
  logic [2:0]          straps = STRAP_DIRECT;
  logic [SYSCFG_W-1:0] cfg = 16'h0000;
  logic                irq_clr = 1'b0;
  logic [3:0]          half = 4'h8;
  logic                pin, cpu, pll_en, bypass, irq, failed;
  logic [2:0]          hist = 3'h0;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;

  always #5 clk = ~clk;

  ext_clk_source u_src (.i_clk(clk), .i_run(run), .i_half(half), .o_pin(pin));

  cpu_clock_select u_dut (
    .i_clk(clk), .i_reset(rst), .i_clock_input_pin(pin), .i_clock_select_straps(straps),
    .i_system_config_register(cfg), .i_irq_clear(irq_clr), .o_cpu_clk(cpu),
    .o_pll_enable(pll_en), .o_osc_amp_bypass(bypass), .o_osc_fail_irq(irq), .o_clock_failed(failed));

  // pin history matching the two-flop sync plus output register
  always @(posedge clk) hist <= {hist[1:0], pin};

  // hang guard; the pll lock waits dominate, about 23600 cycles in all
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // reset long enough to load the strap synchroniser
  task automatic start(input logic [2:0] s, input logic dis);
    rst = 1'b1;
    straps = s;
    cfg[OWD_DISABLE_BIT] = dis;
    cyc(3);
    rst = 1'b0;
    cyc(2);
  endtask : start

  // counts input rises and cpu clock toggles over n cycles
  task automatic watch(input int n, output int rises, output int togs);
    logic p, c;
    rises = 0;
    togs = 0;
    p = pin;
    c = cpu;
    repeat (n) begin
      cyc(1);
      if (pin === 1'b1 && p === 1'b0) rises++;
      if (cpu !== c) togs++;
      p = pin;
      c = cpu;
    end
  endtask : watch

  task automatic t_direct();
    int bad;
    bad = 0;
    run = 1'b1;
    start(STRAP_DIRECT, 1'b0);
    check("bypass", 16'h1, 16'(bypass));
    check("pll free run", 16'h1, 16'(pll_en));
    cyc(4);
    repeat (48) begin
      cyc(1);
      if (cpu !== hist[2]) bad++;
    end
    check("direct follow", 16'h0, 16'(bad));
    run = 1'b0;
    cyc(100);
    check("direct failover", 16'h1, 16'(failed));
    $display("test direct done");
  endtask : t_direct

  task automatic t_wd_off();
    run = 1'b1;
    start(STRAP_DIRECT, 1'b1);
    check("pll off", 16'h0, 16'(pll_en));
    run = 1'b0;
    cyc(120);
    check("no failover", 16'h0, 16'(failed));
    check("no irq", 16'h0, 16'(irq));
    $display("test watchdog off done");
  endtask : t_wd_off

  task automatic t_prescale();
    int r, t;
    run = 1'b1;
    start(STRAP_PRESCALE, 1'b0);
    check("bypass", 16'h0, 16'(bypass));
    check("pll free run", 16'h1, 16'(pll_en));
    watch(64, r, t);
    check("halved", 16'h1, 16'(t >= r - 1 && t <= r + 1 && r > 2));
    watch(100, r, t);
    check("kept alive", 16'h0, 16'(failed));
    run = 1'b0;
    cyc(55);
    check("early fail", 16'h0, 16'(failed));
    cyc(35);
    check("failover", 16'h1, 16'(failed));
    check("irq set", 16'h1, 16'(irq));
    run = 1'b1;
    watch(80, r, t);
    check("pll clock toggles", 16'h1, 16'(t >= 19 && t <= 21));
    check("stays failed", 16'h1, 16'(failed));
    irq_clr = 1'b1;
    cyc(1);
    irq_clr = 1'b0;
    cyc(1);
    check("irq cleared", 16'h0, 16'(irq));
    check("still failed", 16'h1, 16'(failed));
    start(STRAP_PRESCALE, 1'b0);
    check("reset clears fail", 16'h0, 16'(failed));
    watch(100, r, t);
    check("no refail", 16'h0, 16'(failed));
    $display("test prescale done");
  endtask : t_prescale

  // slow input so even x8 fits the system clock; settle, then compare rates
  task automatic t_pll();
    logic [2:0] codes [4];
    int         facs [4];
    int r, t;
    codes = '{STRAP_X4, STRAP_X3, STRAP_X8, STRAP_X5};
    facs = '{4, 3, 8, 5};
    half = 4'hF;
    foreach (codes[i]) begin
      run = 1'b1;
      start(codes[i], 1'b0);
      check("pll on", 16'h1, 16'(pll_en));
      check("no bypass", 16'h0, 16'(bypass));
      cyc(1000 * facs[i]);
      watch(600, r, t);
      // two cpu toggles per cpu period, within ten percent of f times the input
      check("multiplied", 16'h1, 16'(t * 10 >= 18 * facs[i] * r && t * 10 <= 22 * facs[i] * r && r > 15));
      run = 1'b0;
      cyc(120);
      check("no supervision", 16'h0, 16'(failed));
    end
    $display("test pll modes done");
  endtask : t_pll

  initial begin
    cyc(1);
    t_direct();
    t_wd_off();
    t_prescale();
    t_pll();
    end_sim();
  end
endmodule : cpu_clock_select_bench
`default_nettype wire
